// ---- pkg/wed_pkg.sv ----
// Purpose: Constants, states and carriers of the wake event detector
// Assumes: 20 MHz device clock, plain register port with 32-bit data
// Notes: Byte order of addresses and CRC is first-on-wire in low bits
`default_nettype none
package wed_pkg;
  // Register offsets
  localparam logic [3:0] WED_REG_CTRL = 4'h0; // wake_control_status_reg
  localparam logic [3:0] WED_REG_ADDR_LO = 4'h4; // own_mac_address 0..3
  localparam logic [3:0] WED_REG_ADDR_HI = 4'h8; // own_mac_address 4..5
  localparam logic [3:0] WED_REG_PAT_CNT = 4'hc; // loaded pattern bytes
  // Control field positions
  localparam int WED_B_PAT_EN = 0; // pattern_wake_en
  localparam int WED_B_REM_EN = 1; // remote_wake_frame_en
  localparam int WED_B_LNK_EN = 2; // link_wake_en
  localparam int WED_B_PME_EN = 3; // wake signal assertion enable
  localparam int WED_B_PAT_FL = 8; // pattern_wake_flag
  localparam int WED_B_REM_FL = 9; // remote_wake_frame_flag
  localparam int WED_B_LNK_FL = 10; // link_wake_flag
  localparam int WED_B_LINK = 12; // current link state
  localparam int WED_B_BUSY = 13; // pattern walk running
  // Power states
  localparam logic [1:0] WED_D0 = 2'h0;
  // Pattern coding
  localparam logic [3:0] WED_NIB_EXT = 4'hf; // value in next byte
  localparam logic [7:0] WED_PAT_END = 8'h00; // end of pattern
  localparam logic [1:0] WED_CRC_LAST = 2'h3; // four expected CRC bytes
  // Remote wake frame coding
  localparam logic [7:0] WED_SYNC_BYTE = 8'hff;
  localparam logic [2:0] WED_SYNC_LEN = 3'h6;
  localparam logic [2:0] WED_ADDR_LAST = 3'h5;
  localparam logic [3:0] WED_REP_LAST = 4'hf; // sixteen copies
  // CRC-32, Ethernet polynomial, reflected form
  localparam logic [31:0] WED_CRC_POLY = 32'hedb88320;
  localparam logic [31:0] WED_CRC_INIT = 32'hffffffff;
  // Pattern walk states, Gray in the order listed
  typedef enum logic [2:0] {
    WED_IDLE = 3'h0, WED_HDR = 3'h1, WED_XSKIP = 3'h3, WED_XLEN = 3'h2,
    WED_SEL = 3'h6, WED_CRC = 3'h7, WED_CMP = 3'h5
  } wed_walk_t;
  // One received byte with its frame verdicts
  typedef struct packed {
    logic vld; // byte valid
    logic sof; // first byte of frame
    logic eof; // last byte of frame
    logic filt_ok; // frame passes rx_filter_mode (at eof)
    logic addr_ok; // destination matches own address (at eof)
    logic bcast; // broadcast destination (at eof)
    logic [7:0] data;
  } wed_rx_t;
  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [31:0] wdata;
  } wed_reg_req_t;
endpackage
`default_nettype wire

// ---- logic/wed_wake_event_detector.sv ----
// Purpose: Wake event detection while the controller sleeps
// Assumes: One clock, synchronous active-low reset, MAC bytes on clock
// Notes: Patterns are walked over a stored copy of a received frame; frames arriving mid-walk are not stored
// Function
// R1: Each source passes only when enabled
// R2: Detection only in D1-D3, never D0; a pattern walk already past its header can still set the pattern flag in D0
// R3: Pattern match sets flag, drives wake
// R4: Pattern match needs receive filter pass
// R5: Host resets transmit path before loading
// R6: Host packs patterns contiguously, bounded capacity
// R7: Host sets fragment length to pattern bytes
// R8: Host sets word alignment field x1
// R9: Host starts load via list pointer
// R10: Byte: skip high nibble, length low
// R11: Skip counts from last selected byte
// R12: Nibble 0xF takes value from next byte
// R13: Byte 0x00 ends pattern, CRC follows
// R14: Ethernet CRC over selected frame bytes
// R15: CRC equal raises wake; aliasing accepted
// R16: Scan for sixteen own address copies
// R17: Copies preceded by six 0xFF bytes
// R18: Needs address match or broadcast
// R19: Remote frame sets flag, drives wake
// R20: Link change after enable sets flag
// R21: Flags sticky; wake while enabled flag
//
// Added by the designer: the plain strobed port and the placing of the registers.
`default_nettype none
module wed_wake_event_detector #(
  parameter int FB_BYTES = 256, // stored frame bytes
  parameter int PAT_BYTES = 256 // pattern store capacity
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Register port
  input wire wed_pkg::wed_reg_req_t reg_i,
  output logic [31:0] reg_rdata_o,
  // Power state from PCI power management
  input wire logic [1:0] pm_state_i,
  // Pattern load from transmit DMA
  input wire logic tx_path_reset_i,
  input wire logic pat_load_i,
  input wire logic [7:0] pat_byte_i,
  // Receive MAC byte stream
  input wire wed_pkg::wed_rx_t rx_i,
  // Link state pin from the PHY
  input wire logic link_up_i,
  // Wake output
  output logic pm_wake_signal_o
);
  import wed_pkg::*;
  localparam int FB_AW = $clog2(FB_BYTES);
  localparam int PA_AW = $clog2(PAT_BYTES) + 1;

  // CRC-32 update by one byte, reflected
  function automatic logic [31:0] crc_upd(input logic [31:0] c,
                                          input logic [7:0] b);
    logic [31:0] r;
    r = c ^ {24'h000000, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ WED_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Storage and shared signals
  logic [7:0] pmem [PAT_BYTES]; // Pattern pseudo-packet
  logic [7:0] fbuf [FB_BYTES]; // Copy of the current frame
  logic [PA_AW-1:0] pcnt_q, pcnt_d; // Bytes loaded
  logic [15:0] wpos_q, wpos_d; // Frame write position
  logic link_m_q, link_s_q; // Link pin synchroniser
  logic sleep; // Detection allowed
  logic busy; // Pattern walk running
  logic pat_hit; // One-cycle pattern match
  logic rem_hit; // One-cycle remote frame match
  logic start; // Launch pattern walk
  logic [47:0] own_addr;
  logic [3:0] en_q, en_d; // Enable bits
  logic [2:0] fl_q, fl_d; // Sticky flags
  logic [31:0] addr_lo_q, addr_lo_d;
  logic [15:0] addr_hi_q, addr_hi_d;
  logic link_ref_q, link_ref_d; // Link state baseline
  logic wake_q, wake_d;
  logic [31:0] rdata_q, rdata_d;

  assign sleep = (pm_state_i != WED_D0); // R2
  assign own_addr = {addr_hi_q, addr_lo_q};
  assign reg_rdata_o = rdata_q;
  assign pm_wake_signal_o = wake_q;

  ////////////////////////////////////////////////////////////////////////
  // Register file, flags, link watch and wake output
  always_comb begin
    logic [2:0] clr;
    logic lnk_ev;
    clr = 3'h0;
    lnk_ev = 1'b0;
    en_d = en_q;
    addr_lo_d = addr_lo_q;
    addr_hi_d = addr_hi_q;
    rdata_d = 32'h00000000; // Unmapped and idle read as zero
    if (reg_i.wr) begin
      case (reg_i.addr)
        WED_REG_CTRL: begin
          en_d = reg_i.wdata[WED_B_PME_EN:WED_B_PAT_EN];
          clr = reg_i.wdata[WED_B_LNK_FL:WED_B_PAT_FL]; // Write one clears
        end
        WED_REG_ADDR_LO: addr_lo_d = reg_i.wdata;
        WED_REG_ADDR_HI: addr_hi_d = reg_i.wdata[15:0];
        default: ;
      endcase
    end
    if (reg_i.rd) begin
      case (reg_i.addr)
        WED_REG_CTRL: begin
          rdata_d[WED_B_PME_EN:WED_B_PAT_EN] = en_q;
          rdata_d[WED_B_LNK_FL:WED_B_PAT_FL] = fl_q;
          rdata_d[WED_B_LINK] = link_s_q;
          rdata_d[WED_B_BUSY] = busy;
        end
        WED_REG_ADDR_LO: rdata_d = addr_lo_q;
        WED_REG_ADDR_HI: rdata_d[15:0] = addr_hi_q;
        WED_REG_PAT_CNT: rdata_d[PA_AW-1:0] = pcnt_q;
        default: ;
      endcase
    end
    // Baseline taken when enable rises, and held fresh while in D0
    link_ref_d = link_ref_q;
    if ((en_d[WED_B_LNK_EN] && !en_q[WED_B_LNK_EN]) || !sleep) begin
      link_ref_d = link_s_q; // R20
    end
    lnk_ev = en_q[WED_B_LNK_EN] && sleep && (link_s_q != link_ref_q); // R20
    if (lnk_ev) begin
      link_ref_d = link_s_q;
    end
    // Hardware set wins over a clear in the same cycle
    fl_d = fl_q & ~clr; // R21
    if (pat_hit) begin
      fl_d[0] = 1'b1; // R3
    end
    if (rem_hit) begin
      fl_d[1] = 1'b1; // R19
    end
    if (lnk_ev) begin
      fl_d[2] = 1'b1; // R20
    end
    // Wake stands while assertion is enabled and any enabled flag is set, never from D0
    wake_d = en_q[WED_B_PME_EN] && sleep &&
             |(fl_q & en_q[WED_B_LNK_EN:WED_B_PAT_EN]); // R1 R21
  end

  // Register stage of the control group
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      en_q <= 4'h0;
      fl_q <= 3'h0;
      addr_lo_q <= 32'h00000000;
      addr_hi_q <= 16'h0000;
      link_ref_q <= 1'b0;
      wake_q <= 1'b0;
      rdata_q <= 32'h00000000;
      link_m_q <= 1'b0;
      link_s_q <= 1'b0;
    end else begin
      en_q <= en_d;
      fl_q <= fl_d;
      addr_lo_q <= addr_lo_d;
      addr_hi_q <= addr_hi_d;
      link_ref_q <= link_ref_d;
      wake_q <= wake_d;
      rdata_q <= rdata_d;
      link_m_q <= link_up_i;
      link_s_q <= link_m_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pattern load and frame capture
  always_comb begin
    pcnt_d = pcnt_q;
    if (tx_path_reset_i) begin
      pcnt_d = '0; // Pointer reset before a reload
    end else if (pat_load_i && pcnt_q < PA_AW'(PAT_BYTES)) begin
      pcnt_d = pcnt_q + 1'b1; // Excess bytes dropped at capacity
    end
    wpos_d = wpos_q;
    if (rx_i.vld) begin
      wpos_d = rx_i.sof ? 16'h0001 : wpos_q + 16'h0001;
    end
  end

  // Memories written here; a frame arriving mid-walk is not stored
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      pcnt_q <= '0;
      wpos_q <= 16'h0000;
    end else begin
      pcnt_q <= pcnt_d;
      wpos_q <= wpos_d;
      if (pat_load_i && !tx_path_reset_i && pcnt_q < PA_AW'(PAT_BYTES)) begin
        pmem[pcnt_q[PA_AW-2:0]] <= pat_byte_i;
      end
      if (rx_i.vld && !busy) begin
        if (rx_i.sof) begin
          fbuf[0] <= rx_i.data;
        end else if (wpos_q < 16'(FB_BYTES)) begin
          fbuf[wpos_q[FB_AW-1:0]] <= rx_i.data;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Remote wake frame scanner, runs on the live byte stream
  logic [2:0] ffc_q, ffc_d; // Sync bytes seen, saturating
  logic [2:0] aix_q, aix_d; // Address byte index
  logic [3:0] rep_q, rep_d; // Address copy count
  logic inseq_q, inseq_d; // Inside address copies
  logic found_q, found_d; // Sequence seen this frame
  always_comb begin
    logic [7:0] ab;
    logic fnd;
    ffc_d = ffc_q;
    aix_d = aix_q;
    rep_d = rep_q;
    inseq_d = inseq_q;
    found_d = found_q;
    fnd = 1'b0;
    ab = own_addr[8*aix_q +: 8]; // Byte 0 is first on the wire
    rem_hit = 1'b0;
    if (rx_i.vld) begin
      if (rx_i.sof) begin
        found_d = 1'b0;
        inseq_d = 1'b0;
        ffc_d = 3'h0;
      end
      if (inseq_d && rx_i.data == ab) begin
        inseq_d = 1'b1;
        if (aix_q == WED_ADDR_LAST) begin
          aix_d = 3'h0;
          rep_d = rep_q + 4'h1;
          fnd = (rep_q == WED_REP_LAST); // R16
          inseq_d = !fnd;
        end else begin
          aix_d = aix_q + 3'h1;
        end
      end else if (ffc_d == WED_SYNC_LEN &&
                   rx_i.data == own_addr[7:0]) begin
        inseq_d = 1'b1; // R17
        aix_d = 3'h1;
        rep_d = 4'h0;
        ffc_d = 3'h0;
      end else begin
        inseq_d = 1'b0;
        if (rx_i.data == WED_SYNC_BYTE) begin
          ffc_d = (ffc_d == WED_SYNC_LEN) ? ffc_d : ffc_d + 3'h1; // R17
        end else begin
          ffc_d = 3'h0;
        end
      end
      found_d = found_d | fnd; // R16
      if (rx_i.eof) begin
        rem_hit = (found_q | fnd) && sleep && en_q[WED_B_REM_EN] &&
                  (rx_i.addr_ok || rx_i.bcast); // R1 R18
      end
    end
  end

  // Register stage of the scanner
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      ffc_q <= 3'h0;
      aix_q <= 3'h0;
      rep_q <= 4'h0;
      inseq_q <= 1'b0;
      found_q <= 1'b0;
    end else begin
      ffc_q <= ffc_d;
      aix_q <= aix_d;
      rep_q <= rep_d;
      inseq_q <= inseq_d;
      found_q <= found_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pattern walk over the stored frame, at most one pattern or frame byte per cycle
  wed_walk_t st_q, st_d;
  logic [PA_AW-1:0] ptr_q, ptr_d; // Pattern read pointer
  logic [15:0] pos_q, pos_d; // Frame byte position
  logic [15:0] flen_q, flen_d; // Stored frame length
  logic [7:0] len_q, len_d; // Bytes left to select
  logic xlen_q, xlen_d; // Length comes from next byte
  logic miss_q, miss_d; // Selected byte beyond frame
  logic [1:0] cc_q, cc_d; // Expected CRC byte count
  logic [31:0] crc_q, crc_d, exp_q, exp_d;
  logic [7:0] pb;
  assign busy = (st_q != WED_IDLE);
  assign pb = pmem[ptr_q[PA_AW-2:0]];
  assign start = rx_i.vld && rx_i.eof && !busy && sleep &&
                 en_q[WED_B_PAT_EN] && rx_i.filt_ok; // R1 R4
  always_comb begin
    st_d = st_q;
    ptr_d = ptr_q;
    pos_d = pos_q;
    flen_d = flen_q;
    len_d = len_q;
    xlen_d = xlen_q;
    miss_d = miss_q;
    cc_d = cc_q;
    crc_d = crc_q;
    exp_d = exp_q;
    pat_hit = 1'b0;
    case (st_q)
      WED_IDLE: begin
        if (start) begin
          st_d = WED_HDR;
          ptr_d = '0;
          pos_d = 16'h0000; // R11
          flen_d = rx_i.sof ? 16'h0001 : wpos_q + 16'h0001;
          crc_d = WED_CRC_INIT;
          miss_d = 1'b0;
        end
      end
      WED_HDR: begin
        if (ptr_q >= pcnt_q || !sleep) begin
          st_d = WED_IDLE; // All patterns done, or back in D0
        end else begin
          ptr_d = ptr_q + 1'b1;
          if (pb == WED_PAT_END) begin
            st_d = WED_CRC; // R13
            cc_d = 2'h0;
          end else begin
            xlen_d = (pb[3:0] == WED_NIB_EXT); // R12
            len_d = {4'h0, pb[3:0]}; // R10
            if (pb[7:4] == WED_NIB_EXT) begin
              st_d = WED_XSKIP; // R12
            end else begin
              pos_d = pos_q + {12'h000, pb[7:4]}; // R10 R11
              st_d = xlen_d ? WED_XLEN : WED_SEL;
            end
          end
        end
      end
      WED_XSKIP: begin
        ptr_d = ptr_q + 1'b1;
        pos_d = pos_q + {8'h00, pb}; // R12
        st_d = xlen_q ? WED_XLEN : WED_SEL;
      end
      WED_XLEN: begin
        ptr_d = ptr_q + 1'b1;
        len_d = pb; // R12
        st_d = WED_SEL;
      end
      WED_SEL: begin
        if (len_q == 8'h00) begin
          st_d = WED_HDR;
        end else begin
          if (pos_q < flen_q) begin
            crc_d = crc_upd(crc_q, fbuf[pos_q[FB_AW-1:0]]); // R14
          end else begin
            miss_d = 1'b1; // Short frame cannot match
          end
          pos_d = pos_q + 16'h0001;
          len_d = len_q - 8'h01;
        end
      end
      WED_CRC: begin
        ptr_d = ptr_q + 1'b1;
        exp_d = {pb, exp_q[31:8]}; // R13
        cc_d = cc_q + 2'h1;
        if (cc_q == WED_CRC_LAST) begin
          st_d = WED_CMP;
        end
      end
      WED_CMP: begin
        // Aliasing byte values may also match; accepted
        pat_hit = !miss_q && ((~crc_q) == exp_q); // R15
        st_d = WED_HDR;
        pos_d = 16'h0000;
        crc_d = WED_CRC_INIT;
        miss_d = 1'b0;
      end
      default: st_d = WED_IDLE;
    endcase
  end

  // Register stage of the walk
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      st_q <= WED_IDLE;
      ptr_q <= '0;
      pos_q <= 16'h0000;
      flen_q <= 16'h0000;
      len_q <= 8'h00;
      xlen_q <= 1'b0;
      miss_q <= 1'b0;
      cc_q <= 2'h0;
      crc_q <= WED_CRC_INIT;
      exp_q <= 32'h00000000;
    end else begin
      st_q <= st_d;
      ptr_q <= ptr_d;
      pos_q <= pos_d;
      flen_q <= flen_d;
      len_q <= len_d;
      xlen_q <= xlen_d;
      miss_q <= miss_d;
      cc_q <= cc_d;
      crc_q <= crc_d;
      exp_q <= exp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_link_flip;
    en_q[WED_B_LNK_EN] && sleep && (link_s_q != link_ref_q);
  endsequence
  sequence s_bad_read;
    reg_i.rd && (reg_i.addr > WED_REG_PAT_CNT ||
                 reg_i.addr[1:0] != 2'h0);
  endsequence
  a_wake_d0_quiet: assert property (@(posedge clock_i) disable iff // R2
    (!resetn_i) (pm_state_i == WED_D0) |=> !pm_wake_signal_o)
    else $error("wake driven in D0");
  a_wake_has_cause: assert property (@(posedge clock_i) disable iff // R1
    (!resetn_i) pm_wake_signal_o |-> $past(en_q[WED_B_PME_EN]) &&
    $past(|(fl_q & en_q[WED_B_LNK_EN:WED_B_PAT_EN])))
    else $error("wake without enabled flag");
  a_flag_sticky: assert property (@(posedge clock_i) disable iff // R21
    (!resetn_i) fl_q[0] && !(reg_i.wr && reg_i.addr == WED_REG_CTRL)
    |=> fl_q[0])
    else $error("pattern flag dropped");
  a_set_beats_clr: assert property (@(posedge clock_i) disable iff // R19
    (!resetn_i) rem_hit |=> fl_q[1])
    else $error("remote flag lost");
  a_link_event: assert property (@(posedge clock_i) disable iff // R20
    (!resetn_i) s_link_flip |=> fl_q[2] ##0 (link_ref_q == $past(link_s_q)))
    else $error("link change not flagged");
  a_pat_gate: assert property (@(posedge clock_i) disable iff // R15
    (!resetn_i) pat_hit |-> st_q == WED_CMP && !miss_q)
    else $error("pattern hit outside compare");
  a_pat_flag: assert property (@(posedge clock_i) disable iff // R3
    (!resetn_i) pat_hit |=> fl_q[0])
    else $error("pattern flag lost");
  a_walk_start: assert property (@(posedge clock_i) disable iff // R4
    (!resetn_i) start |=> st_q == WED_HDR ##1 st_q != WED_IDLE ||
    ptr_q == '0)
    else $error("walk did not start");
  a_rd_unmapped: assert property (@(posedge clock_i) disable iff
    (!resetn_i) s_bad_read |=> reg_rdata_o == 32'h00000000)
    else $error("unmapped read not zero");
endmodule
`default_nettype wire

// ---- tb/wed_mac_model.sv ----
// Purpose: Receive MAC byte stream and pattern-loading DMA in front of dut
// Assumes: Bytes move one per clock, verdicts valid with the last byte
// Notes: Idle data shows the inverse of the last byte, never a stale copy
`default_nettype none
module wed_mac_model (
  // Clock
  input wire logic clock_i,
  // Receive stream towards the detector
  output wed_pkg::wed_rx_t rx_o,
  // Pattern load path
  output logic tx_path_reset_o,
  output logic pat_load_o,
  output logic [7:0] pat_byte_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import wed_pkg::*;
  ////////////////////////////////////////////////////////////////////////
  logic [7:0] q [$]; // Bytes staged for the next transfer
  logic [7:0] last_b; // Last byte put on the line
  initial begin
    rx_o = '0;
    tx_path_reset_o = 1'b0;
    pat_load_o = 1'b0;
    pat_byte_o = 8'h5a;
    last_b = 8'h00;
  end
  // Stage one byte
  task add(input logic [7:0] b);
    q.push_back(b);
  endtask
  // Released line: inverse of last byte so nothing reads as still valid
  task idle();
    rx_o <= {6'h00, ~last_b};
  endtask
  // One frame; slow inserts an idle cycle mid-frame
  task send(input logic fok, input logic aok, input logic bc,
            input logic slow);
    int n;
    n = q.size();
    for (int i = 0; i < n; i++) begin
      @(posedge clock_i);
      if (slow && i == n / 2) begin
        idle();
        @(posedge clock_i);
      end
      rx_o <= {1'b1, i == 0, i == n - 1, fok, aok, bc, q[i]};
      last_b = q[i];
    end
    @(posedge clock_i);
    idle();
    q.delete();
  endtask
  // Pseudo-frame load: path reset first, then contiguous bytes
  task load();
    @(posedge clock_i);
    tx_path_reset_o <= 1'b1;
    @(posedge clock_i);
    tx_path_reset_o <= 1'b0;
    foreach (q[i]) begin
      @(posedge clock_i);
      pat_load_o <= 1'b1;
      pat_byte_o <= q[i];
    end
    @(posedge clock_i);
    pat_load_o <= 1'b0;
    pat_byte_o <= ~pat_byte_o;
    q.delete();
  endtask
endmodule
`default_nettype wire

// ---- tb/wake_event_detector_bench.sv ----
// Purpose: Self-checking bench of the wake event detector
// Assumes: 20 MHz clock, register port with read data one cycle later
// Notes: Random frames from a fixed seed, corner cases from small tables
`default_nettype none
module wake_event_detector_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import wed_pkg::*;
  ////////////////////////////////////////////////////////////////////////
  logic clock, resetn, link_up, wake, txr, pl;
  logic [1:0] pm; // Power state seen by dut
  logic [7:0] pb;
  logic [31:0] rdata, v;
  wed_reg_req_t req;
  wed_rx_t rx;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  int seed = 58156;
  int pn; // Pattern bytes staged
  logic [7:0] adr [6]; // Own station address
  logic [7:0] fr [60]; // Target frame of a pattern round
  logic [7:0] fx [60];
  int sk [4] = '{12, 7, 16, 20}; // Skip per selection entry
  int ln [4] = '{2, 16, 4, 17}; // Length per entry, 15 and up takes next byte
  wed_wake_event_detector #(.FB_BYTES(256), .PAT_BYTES(64)) dut (
    .clock_i(clock), .resetn_i(resetn), .reg_i(req),
    .reg_rdata_o(rdata), .pm_state_i(pm), .tx_path_reset_i(txr),
    .pat_load_i(pl), .pat_byte_i(pb), .rx_i(rx), .link_up_i(link_up),
    .pm_wake_signal_o(wake));
  wed_mac_model mac (.clock_i(clock), .rx_o(rx), .tx_path_reset_o(txr),
    .pat_load_o(pl), .pat_byte_o(pb));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // Cut a hang short
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      report_and_stop();
    end
  end
  task report_and_stop();
    if (err_total == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // Bus cycles: strobe one cycle, a gap edge before the next
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    req <= '0;
  endtask
  task rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clock);
    req <= '0;
    #1 d = rdata;
  endtask
  // Flag bit and wake level against expectation
  task ev(input int b, input logic ef, input logic ew, input string m);
    logic [31:0] s;
    rd(WED_REG_CTRL, s);
    chk({31'h0, s[b]}, {31'h0, ef}, m);
    chk({31'h0, wake}, {31'h0, ew}, m);
  endtask
  // Poll until the pattern walk is done, bounded
  task wait_idle();
    logic [31:0] s;
    repeat (4) @(posedge clock);
    for (int k = 0; k < 400; k++) begin
      rd(WED_REG_CTRL, s);
      if (s[WED_B_BUSY] === 1'b0) break;
    end
    repeat (4) @(posedge clock);
  endtask
  // Reflected CRC-32, inverted at the end
  function automatic logic [31:0] crc_sel(input int lo, input int hi);
    logic [31:0] c;
    int p;
    c = WED_CRC_INIT;
    p = 0;
    for (int e = lo; e <= hi; e++) begin
      p += sk[e];
      for (int j = 0; j < ln[e]; j++) begin
        c ^= {24'h0, fr[p]};
        repeat (8) c = c[0] ? (c >> 1) ^ WED_CRC_POLY : c >> 1;
        p++;
      end
    end
    return ~c;
  endfunction
  task padd(input logic [7:0] b);
    mac.add(b);
    pn++;
  endtask
  // Encode entries lo..hi, end byte, expected CRC low byte first
  task enc(input int lo, input int hi, input logic [31:0] c);
    for (int e = lo; e <= hi; e++) begin
      if (sk[e] >= 15 && ln[e] >= 15) begin
        padd(8'hff);
        padd(8'(sk[e]));
        padd(8'(ln[e]));
      end else if (sk[e] >= 15) begin
        padd({4'hf, 4'(ln[e])});
        padd(8'(sk[e]));
      end else if (ln[e] >= 15) begin
        padd({4'(sk[e]), 4'hf});
        padd(8'(ln[e]));
      end else padd({4'(sk[e]), 4'(ln[e])});
    end
    padd(WED_PAT_END);
    for (int i = 0; i < 4; i++) padd(c[8*i +: 8]);
  endtask
  // Remote wake frame: filler, sync run, address copies, tail
  task rem(input int pre, input int sy, input int cp, input logic aok,
           input logic bc);
    for (int i = 0; i < pre; i++) mac.add(8'($random(seed)) & 8'h7f);
    repeat (sy) mac.add(WED_SYNC_BYTE);
    repeat (cp) foreach (adr[i]) mac.add(adr[i]);
    repeat (2) mac.add(8'($random(seed)) & 8'h7f);
    mac.send(1'b0, aok, bc, 1'b0);
    repeat (6) @(posedge clock);
  endtask
  ////////////////////////////////////////////////////////////////////////
  int rp [6] = '{3, 0, 2, 1, 1, 4}; // Filler bytes
  int rs [6] = '{6, 5, 6, 6, 6, 7}; // Sync run length
  int rc [6] = '{16, 16, 15, 16, 16, 16}; // Address copies
  logic ra [6] = '{1, 1, 1, 0, 0, 1}; // Address match verdict
  logic rb [6] = '{0, 0, 0, 0, 1, 0}; // Broadcast verdict
  logic re [6] = '{1, 0, 0, 0, 1, 1};
  int mi [6] = '{-1, 55, 5, -1, 12, 21}; // Byte corrupted, -1 none
  logic pf [6] = '{1, 1, 1, 0, 1, 1}; // Filter verdict
  // Either pattern matching wakes; byte 21 lies in both selections
  logic pe [6] = '{1, 1, 1, 0, 1, 0};
  initial begin
    resetn = 1'b0;
    req = '0;
    pm = WED_D0;
    link_up = 1'b1;
    foreach (adr[i]) adr[i] = 8'($random(seed)) & 8'h7e;
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    ev(WED_B_REM_FL, 1'b0, 1'b0, "reset");
    rd(WED_REG_PAT_CNT, v);
    chk(v, 32'h0, "reset count");
    wr(WED_REG_ADDR_LO, {adr[3], adr[2], adr[1], adr[0]});
    wr(WED_REG_ADDR_HI, {16'h0, adr[5], adr[4]});
    rd(WED_REG_ADDR_HI, v);
    chk(v, {16'h0, adr[5], adr[4]}, "address");
    rd(4'h2, v);
    chk(v, 32'h0, "unmapped read");
    // Remote wake frames, all variants asleep, then assertion off, disabled and awake
    pm <= 2'h3;
    wr(WED_REG_CTRL, 32'hb);
    for (int c = 0; c < 6; c++) begin
      rem(rp[c], rs[c], rc[c], ra[c], rb[c]);
      repeat (20) @(posedge clock);
      ev(WED_B_REM_FL, re[c], re[c], "remote");
      wr(WED_REG_CTRL, 32'h20b);
      ev(WED_B_REM_FL, 1'b0, 1'b0, "clear");
    end
    wr(WED_REG_CTRL, 32'h3);
    rem(0, 6, 16, 1'b1, 1'b0);
    ev(WED_B_REM_FL, 1'b1, 1'b0, "assert off");
    wr(WED_REG_CTRL, 32'h209);
    rem(0, 6, 16, 1'b1, 1'b0);
    ev(WED_B_REM_FL, 1'b0, 1'b0, "disabled");
    pm <= WED_D0;
    wr(WED_REG_CTRL, 32'hb);
    rem(0, 6, 16, 1'b1, 1'b0);
    ev(WED_B_REM_FL, 1'b0, 1'b0, "awake");
    // Pattern rounds on random frames
    for (int r = 0; r < 2; r++) begin
      foreach (fr[i]) fr[i] = 8'($random(seed));
      pm <= WED_D0;
      pn = 0;
      enc(0, 2, crc_sel(0, 2));
      enc(3, 3, crc_sel(3, 3));
      mac.load();
      rd(WED_REG_PAT_CNT, v);
      chk(v, 32'(pn), "count");
      pm <= 2'h3;
      wr(WED_REG_CTRL, 32'hb);
      for (int c = 0; c < 6; c++) begin
        fx = fr;
        if (mi[c] >= 0) fx[mi[c]] ^= 8'h01;
        foreach (fx[i]) mac.add(fx[i]);
        mac.send(pf[c], 1'b0, 1'b0, c[0]);
        wait_idle();
        ev(WED_B_PAT_FL, pe[c], pe[c], "pattern");
        wr(WED_REG_CTRL, 32'h10b);
      end
    end
    // Link change both ways, then disabled and awake
    wr(WED_REG_CTRL, 32'hc);
    repeat (8) @(posedge clock);
    ev(WED_B_LNK_FL, 1'b0, 1'b0, "link still");
    link_up <= 1'b0;
    repeat (8) @(posedge clock);
    ev(WED_B_LNK_FL, 1'b1, 1'b1, "link down");
    wr(WED_REG_CTRL, 32'h408);
    wr(WED_REG_CTRL, 32'hc);
    link_up <= 1'b1;
    repeat (8) @(posedge clock);
    ev(WED_B_LNK_FL, 1'b1, 1'b1, "link up");
    wr(WED_REG_CTRL, 32'h408);
    link_up <= 1'b0;
    repeat (8) @(posedge clock);
    ev(WED_B_LNK_FL, 1'b0, 1'b0, "link off");
    wr(WED_REG_CTRL, 32'hc);
    pm <= WED_D0;
    link_up <= 1'b1;
    repeat (8) @(posedge clock);
    ev(WED_B_LNK_FL, 1'b0, 1'b0, "link awake");
    report_and_stop();
  end
endmodule
`default_nettype wire
